/* design/rmm_datapath.sv */
// rmm_datapath.sv: rotate/mask/merge operand datapath, top level
// assumes one 125 MHz clock; bus bank inputs arrive asynchronously
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rmm_regs.svh"

// What this block does
// - register moves right-rotate source, source kept
// - overflow only on ADD, never a destination
// - accumulator copy feeds AND, ADD, XOR only
// - MOVE, AND, ADD, XOR in both formats
// - register destinations R0-R6, R9-R14, bank addresses
// - bank address destination drives bus and stores
// - register-to-bus-address loads PC from AR
// - bank field 2 left, 3 right
// - length 1-7 low bits, 0 full byte
// - latch bank, shift source, merge, output
// - merge keeps latched bits outside field
// - destination position aligns field LSB
// - bus-to-register rotates, masks, zeroes high bits
// - bus-to-bus rotate, mask, shift, merge, output
// - bus-to-address masks, zeroes rest, emits address
// - emitted address held in bank register
// - second ALU operand is accumulator R0
// - bank address shown with select-command strobe high
module rmm_datapath
  import rmm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] left_io_vector_bus_in,
  input wire logic [7:0] right_io_vector_bus_in,
  output rmm_bank_out_s left_io_vector_drive,
  output rmm_bank_out_s right_io_vector_drive
);

  typedef struct packed {
    rmm_state_e fsm;
    rmm_instr_s ins;
    logic [7:0] aux;
    logic ovf;
    logic err;
    rmm_addr_t pc;
    rmm_addr_t ar;
    logic [7:0] left_latch;
    logic [7:0] right_latch;
    logic [7:0] l_s1;
    logic [7:0] l_s2;
    logic [7:0] l_s3;
    logic [7:0] l_in;
    logic [7:0] r_s1;
    logic [7:0] r_s2;
    logic [7:0] r_s3;
    logic [7:0] r_in;
    rmm_bank_out_s left_drive;
    rmm_bank_out_s right_drive;
    logic [31:0] rdata;
    logic rd_mem;
  } rmm_dp_state_s;

  rmm_dp_state_s s_reg;
  rmm_dp_state_s s_next;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [3:0] mem_raddr;
  logic [7:0] mem_q;
  logic src_bus;
  logic dst_bus;
  logic dst_addr_reg;
  logic bad;
  logic [7:0] src_byte;
  logic [7:0] dst_latch;
  logic [7:0] operand;
  logic [8:0] alu;
  logic [7:0] result;
  logic [7:0] merge_mask;

  // circular: bits leaving bit 0 come back in at bit 7
  function automatic logic [7:0] rot_right(input logic [7:0] v,
                                           input logic [2:0] n);
    logic [15:0] w;
    w = {v, v} >> n;
    return w[7:0];
  endfunction : rot_right
  function automatic logic [7:0] len_mask(input logic [2:0] len);
    logic [7:0] m;
    m = ~(8'hFF << len);
    if (len == `RMM_FULL_LEN) begin
      m = 8'hFF;
    end
    return m;
  endfunction : len_mask
  function automatic logic bank_right(input logic [1:0] field);
    return field == `RMM_BANK_RIGHT;
  endfunction : bank_right
  function automatic logic win_hit(input logic [7:0] a);
    return a[`RMM_WIN_SEL_F] == `RMM_WIN_SEL && a[`RMM_WIN_ALIGN_F] == 2'h0;
  endfunction : win_hit

  rmm_regfile #(
    .DEPTH(16),
    .WIDTH(8),
    .AW(4)
  ) u_regfile (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  always_comb begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_waddr = 4'h0;
    mem_wdata = 8'h00;
    mem_raddr = 4'h0;
    src_bus = s_reg.ins.src[4];
    dst_bus = s_reg.ins.dst[4];
    dst_addr_reg = !dst_bus && (s_reg.ins.dst[3:0] == `RMM_IDX_LEFT_ADDR ||
                   s_reg.ins.dst[3:0] == `RMM_IDX_RIGHT_ADDR);
    bad = 1'b0;
    src_byte = bank_right(s_reg.ins.src[4:3]) ? s_reg.right_latch
                                              : s_reg.left_latch;
    dst_latch = bank_right(s_reg.ins.dst[4:3]) ? s_reg.right_latch
                                               : s_reg.left_latch;
    operand = 8'h00;
    alu = 9'h000;
    result = 8'h00;
    merge_mask = 8'h00;
    {s_next.left_drive.oe, s_next.left_drive.sel} = 2'h0;
    {s_next.right_drive.oe, s_next.right_drive.sel} = 2'h0;
    s_next.rd_mem = 1'b0;
    s_next.rdata = 32'h0000_0000;
    // bank inputs: a new value counts once stages two and three agree
    s_next.l_s1 = left_io_vector_bus_in;
    s_next.l_s2 = s_reg.l_s1;
    s_next.l_s3 = s_reg.l_s2;
    s_next.r_s1 = right_io_vector_bus_in;
    s_next.r_s2 = s_reg.r_s1;
    s_next.r_s3 = s_reg.r_s2;
    if (s_reg.l_s2 == s_reg.l_s3) begin
      s_next.l_in = s_reg.l_s3;
    end
    if (s_reg.r_s2 == s_reg.r_s3) begin
      s_next.r_in = s_reg.r_s3;
    end

    if (reg_rd) begin
      if (reg_addr == `RMM_OFS_INSTR) begin
        s_next.rdata = {16'h0000, s_reg.ins};
      end else if (reg_addr == `RMM_OFS_ADDR) begin
        s_next.rdata = {19'h00000, s_reg.ar};
      end else if (reg_addr == `RMM_OFS_PC) begin
        s_next.rdata = {19'h00000, s_reg.pc};
      end else if (reg_addr == `RMM_OFS_STATUS) begin
        s_next.rdata[`RMM_ST_BUSY] = s_reg.fsm != st_idle;
        s_next.rdata[`RMM_ST_OVF] = s_reg.ovf;
        s_next.rdata[`RMM_ST_ERR] = s_reg.err;
      end else if (win_hit(reg_addr) && s_reg.fsm == st_idle) begin
        if (reg_addr[`RMM_WIN_IDX_F] == `RMM_IDX_OVF) begin
          s_next.rdata = {31'h0000_0000, s_reg.ovf};
        end else begin
          mem_raddr = reg_addr[`RMM_WIN_IDX_F];
          s_next.rd_mem = 1'b1;
        end
      end
    end

    case (s_reg.fsm)
      st_idle: begin
        if (reg_wr) begin
          if (reg_addr == `RMM_OFS_INSTR) begin
            s_next.ins = rmm_instr_s'(reg_wdata[`RMM_INSTR_F]);
            s_next.fsm = st_read;
          end else if (reg_addr == `RMM_OFS_ADDR) begin
            s_next.ar = reg_wdata[`RMM_ADDR_F];
          end else if (win_hit(reg_addr) &&
                       reg_addr[`RMM_WIN_IDX_F] != `RMM_IDX_OVF) begin
            mem_we = 1'b1;
            mem_waddr = reg_addr[`RMM_WIN_IDX_F];
            mem_wdata = reg_wdata[7:0];
            if (mem_waddr == `RMM_IDX_ACC) begin
              s_next.aux = reg_wdata[7:0];
            end
          end
        end
      end
      st_read: begin
        // bank bytes are latched in the same cycle the source is read
        s_next.left_latch = s_reg.l_in;
        s_next.right_latch = s_reg.r_in;
        mem_raddr = s_reg.ins.src[3:0];
        s_next.fsm = st_exec;
      end
      st_exec: begin
        if (!src_bus && !dst_bus) begin
          operand = rot_right(mem_q, s_reg.ins.len);
        end else if (!src_bus) begin
          operand = mem_q & len_mask(s_reg.ins.len);
        end else begin
          operand = rot_right(src_byte, s_reg.ins.src[2:0]) &
                    len_mask(s_reg.ins.len);
        end
        case (s_reg.ins.op)
          `RMM_OP_MOVE: alu = {1'b0, operand};
          `RMM_OP_ADD: alu = {1'b0, operand} + {1'b0, s_reg.aux};
          `RMM_OP_AND: alu = {1'b0, operand & s_reg.aux};
          `RMM_OP_XOR: alu = {1'b0, operand ^ s_reg.aux};
          default: bad = 1'b1;
        endcase
        if (!dst_bus && s_reg.ins.dst[3:0] == `RMM_IDX_OVF) begin
          bad = 1'b1;
        end
        s_next.err = bad;
        s_next.pc = s_reg.pc + 13'h0001;
        s_next.ar = s_reg.pc + 13'h0001;
        s_next.fsm = st_idle;
        result = alu[7:0];
        if (!bad) begin
          if (s_reg.ins.op == `RMM_OP_ADD) begin
            s_next.ovf = alu[8];
          end
          if (dst_bus) begin
            // shifted-out high bits are dropped, not wrapped
            merge_mask = len_mask(s_reg.ins.len) << s_reg.ins.dst[2:0];
            result = (dst_latch & ~merge_mask) |
                     ((alu[7:0] << s_reg.ins.dst[2:0]) & merge_mask);
            if (bank_right(s_reg.ins.dst[4:3])) begin
              s_next.right_drive.data = result;
              s_next.right_drive.oe = 1'b1;
            end else begin
              s_next.left_drive.data = result;
              s_next.left_drive.oe = 1'b1;
            end
          end else begin
            if (src_bus) begin
              result = alu[7:0] & len_mask(s_reg.ins.len);
            end
            mem_we = 1'b1;
            mem_waddr = s_reg.ins.dst[3:0];
            mem_wdata = result;
            if (mem_waddr == `RMM_IDX_ACC) begin
              s_next.aux = result;
            end
            if (dst_addr_reg) begin
              if (s_reg.ins.dst[3:0] == `RMM_IDX_RIGHT_ADDR) begin
                s_next.right_drive.data = result;
                s_next.right_drive.oe = 1'b1;
                s_next.right_drive.sel = 1'b1;
              end else begin
                s_next.left_drive.data = result;
                s_next.left_drive.oe = 1'b1;
                s_next.left_drive.sel = 1'b1;
              end
              if (!src_bus) begin
                s_next.pc = s_reg.ar;
              end
            end
          end
        end
      end
      default: s_next.fsm = st_idle;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.fsm <= st_idle;
      s_reg.pc <= `RMM_PC_RST;
      s_reg.ar <= `RMM_PC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rd_mem ? {24'h000000, mem_q} : s_reg.rdata;
  assign left_io_vector_drive = s_reg.left_drive;
  assign right_io_vector_drive = s_reg.right_drive;

  default clocking dp_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  wire exec_ok = s_reg.fsm == st_exec && !bad;
  ovf_add_only_a: assert property (
    s_reg.fsm == st_exec && s_reg.ins.op != `RMM_OP_ADD |=> $stable(s_reg.ovf))
    else $error("overflow changed on a non-ADD operation");
  ovf_never_dest_a: assert property (
    mem_we |-> mem_waddr != `RMM_IDX_OVF)
    else $error("overflow slot written as destination");
  rr_rotate_move_a: assert property (
    exec_ok && !src_bus && !dst_bus && s_reg.ins.op == `RMM_OP_MOVE
    |-> mem_wdata == {mem_q[0], mem_q[7:1]} || s_reg.ins.len != 3'h1)
    else $error("register move did not rotate by one");
  and_uses_aux_a: assert property (
    exec_ok && !src_bus && !dst_bus && s_reg.ins.op == `RMM_OP_AND
    |-> mem_wdata == (rot_right(mem_q, s_reg.ins.len) & s_reg.aux))
    else $error("AND result does not use accumulator copy");
  bus_reg_zero_a: assert property (
    exec_ok && src_bus && !dst_bus && s_reg.ins.len == 3'h3
    |-> mem_wdata[7:3] == 5'h00)
    else $error("high bits not cleared on bus-to-register");
  left_addr_emit_a: assert property (
    exec_ok && mem_we && mem_waddr == `RMM_IDX_LEFT_ADDR
    |=> left_io_vector_drive.sel && left_io_vector_drive.oe &&
        left_io_vector_drive.data == $past(mem_wdata))
    else $error("left bank address not emitted with stored value");
  sel_needs_oe_a: assert property (
    right_io_vector_drive.sel |-> right_io_vector_drive.oe ##1
    !right_io_vector_drive.sel)
    else $error("select strobe without drive or longer than a cycle");
  pc_from_ar_a: assert property (
    exec_ok && !src_bus && dst_addr_reg |=> s_reg.pc == $past(s_reg.ar))
    else $error("program counter not loaded from address register");
  merge_keep_a: assert property (
    exec_ok && dst_bus && !bank_right(s_reg.ins.dst[4:3])
    |=> (left_io_vector_drive.data & ~$past(merge_mask)) ==
        ($past(s_reg.left_latch) & ~$past(merge_mask)))
    else $error("merge disturbed latched bits outside field");
  seq_timing_a: assert property (
    s_reg.fsm == st_read |=> s_reg.fsm == st_exec ##1 s_reg.fsm == st_idle)
    else $error("operation did not finish in two cycles");
  cover_rr_add_c: cover property (exec_ok && !src_bus && !dst_bus &&
    s_reg.ins.op == `RMM_OP_ADD);
  cover_bus_bus_c: cover property (exec_ok && src_bus && dst_bus);
  cover_bus_addr_c: cover property (exec_ok && src_bus && dst_addr_reg);
endmodule : rmm_datapath
`default_nettype wire

/* design/rmm_pkg.sv */
// rmm_pkg.sv: types shared by the datapath, the i/o device model and the testbench
// assumes rmm_regs.svh holds the numeric codes
package rmm_pkg;

  typedef logic [12:0] rmm_addr_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_read = 3'b010,
    st_exec = 3'b100
  } rmm_state_e;

  // source and dest: bit 4 set means bus, bits 4:3 bank, 2:0 rotate/pos
  typedef struct packed {
    logic [2:0] op;
    logic [4:0] src;
    logic [2:0] len;
    logic [4:0] dst;
  } rmm_instr_s;

  typedef struct packed {
    logic [7:0] data;
    logic oe;
    logic sel;
  } rmm_bank_out_s;

endpackage : rmm_pkg

/* design/rmm_regfile.sv */
// rmm_regfile.sv: working register file, one write and one read port
// assumes the caller never reads and writes the same word in one cycle
`timescale 1ns/10ps
`default_nettype none

module rmm_regfile #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] q;
  } rmm_rf_state_s;

  rmm_rf_state_s s_reg;
  rmm_rf_state_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.q = s_reg.mem[raddr];
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.q;

endmodule : rmm_regfile
`default_nettype wire

/* design/rmm_regs.svh */
// rmm_regs.svh: register offsets, field positions and codes of the
// rotate/mask/merge datapath
// assumes byte addresses on an 8-bit register port, 32-bit data
`ifndef RMM_REGS_SVH
`define RMM_REGS_SVH

`define RMM_OFS_INSTR 8'h00
`define RMM_OFS_ADDR 8'h04
`define RMM_OFS_PC 8'h08
`define RMM_OFS_STATUS 8'h0C
`define RMM_WIN_SEL 2'h1
`define RMM_WIN_SEL_F 7:6
`define RMM_WIN_IDX_F 5:2
`define RMM_WIN_ALIGN_F 1:0

`define RMM_INSTR_F 15:0
`define RMM_ADDR_F 12:0
`define RMM_ST_BUSY 0
`define RMM_ST_OVF 1
`define RMM_ST_ERR 2

`define RMM_OP_MOVE 3'h0
`define RMM_OP_ADD 3'h1
`define RMM_OP_AND 3'h2
`define RMM_OP_XOR 3'h3

`define RMM_IDX_ACC 4'h0
`define RMM_IDX_LEFT_ADDR 4'h7
`define RMM_IDX_OVF 4'h8
`define RMM_IDX_RIGHT_ADDR 4'hF
`define RMM_BANK_RIGHT 2'h3
`define RMM_FULL_LEN 3'h0
`define RMM_PC_RST 13'h0000

`endif

/* tb/rmm_io_dev.sv */
// rmm_io_dev.sv: behavioural i/o devices hanging on one bus bank
// assumes the bank drive struct of the package and the system clock
`timescale 1ns/10ps
`default_nettype none

module rmm_io_dev
  import rmm_pkg::*;
(
  input wire logic sys_clk,
  input wire rmm_bank_out_s drv,
  output var logic [7:0] bus_in
);
  logic [7:0] mem [256];
  logic [7:0] adr;
  logic sel_seen = 1'b0;

  initial bus_in = 8'h5A;

  always @(posedge sys_clk) begin
    if (drv.oe && drv.sel) begin
      adr <= drv.data;
      sel_seen <= 1'b1;
    end else if (drv.oe) begin
      mem[adr] <= drv.data;
    end
    // nobody enabled yet: floating lines, so never a steady value
    bus_in <= sel_seen ? mem[adr] : ~bus_in;
  end
endmodule : rmm_io_dev

`default_nettype wire

/* tb/test_rmm_datapath.sv */
// test_rmm_datapath.sv: random instructions checked against a model
// assumes the register map of the datapath and two i/o device models
`timescale 1ns/10ps
`default_nettype none
`include "rmm_regs.svh"

module test_rmm_datapath
  import rmm_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] bin [2];
  rmm_bank_out_s drv [2];
  logic [31:0] seed = 32'h2333B279;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] r [16];
  logic [7:0] tm [2][256];
  logic [7:0] adr [2];
  logic [12:0] pc = 13'h0000;
  logic [12:0] ar = 13'h0000;
  logic ovf = 1'b0;
  logic err = 1'b0;

  always #4 sys_clk = ~sys_clk;

  rmm_datapath i_dut (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .left_io_vector_bus_in(bin[0]),
    .right_io_vector_bus_in(bin[1]),
    .left_io_vector_drive(drv[0]),
    .right_io_vector_drive(drv[1])
  );
  rmm_io_dev i_left (.sys_clk, .drv(drv[0]), .bus_in(bin[0]));
  rmm_io_dev i_right (.sys_clk, .drv(drv[1]), .bus_in(bin[1]));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] rot(input logic [7:0] v, input logic [2:0] n);
    return 8'({v, v} >> n);
  endfunction : rot

  function automatic logic [7:0] mk(input logic [2:0] l);
    return (l == 3'h0) ? 8'hFF : 8'((9'h001 << l) - 9'h001);
  endfunction : mk

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask : rd

  task automatic check_all();
    logic [31:0] v;
    for (int i = 0; i < 16; i++) begin
      rd(8'h40 + 8'(4 * i), v);
      chk("register", v, (i == 8) ? {31'h0, ovf} : {24'h0, r[i]});
    end
    rd(`RMM_OFS_PC, v);
    chk("program counter", v, {19'h0, pc});
    rd(`RMM_OFS_STATUS, v);
    chk("status", v, {29'h0, err, ovf, 1'b0});
  endtask : check_all

  task automatic exec(input rmm_instr_s ins);
    logic [7:0] src, res, m, out;
    logic [8:0] sum;
    logic bad, sb, db, sel_x, oe_x;
    int b;
    int cnt [2];
    m = mk(ins.len);
    sb = ins.src[4];
    db = ins.dst[4];
    b = int'(ins.dst[3]);
    if (sb) src = rot(tm[ins.src[3]][adr[ins.src[3]]], ins.src[2:0]) & m;
    else if (db) src = r[ins.src[3:0]] & m;
    else src = rot(r[ins.src[3:0]], ins.len);
    sum = {1'b0, src} + {1'b0, r[0]};
    case (ins.op)
      3'h1: res = sum[7:0];
      3'h2: res = src & r[0];
      3'h3: res = src ^ r[0];
      default: res = src;
    endcase
    if (sb) res &= m;
    out = (tm[b][adr[b]] & ~(m << ins.dst[2:0])) | ((res << ins.dst[2:0]) & (m << ins.dst[2:0]));
    bad = ins.op > 3'h3 || (!db && ins.dst[3:0] == 4'h8);
    sel_x = !db;
    oe_x = !bad && (db || ins.dst[2:0] == 3'h7);
    reg_addr <= `RMM_OFS_INSTR;
    reg_wdata <= {16'h0, ins};
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    cnt = '{0, 0};
    repeat (8) begin
      @(negedge sys_clk);
      for (int k = 0; k < 2; k++) begin
        if (drv[k].oe === 1'b1) begin
          cnt[k]++;
          chk("bank select", drv[k].sel, sel_x);
          chk("bank data", drv[k].data, db ? out : res);
        end
      end
    end
    @(posedge sys_clk);
    for (int k = 0; k < 2; k++) chk("bank strobes", cnt[k], (oe_x && k == b) ? 1 : 0);
    err = bad;
    if (!bad) begin
      if (ins.op == 3'h1) ovf = sum[8];
      if (db) tm[b][adr[b]] = out;
      else r[ins.dst[3:0]] = res;
      if (!db && ins.dst[2:0] == 3'h7) adr[b] = res;
    end
    if (!bad && !sb && !db && ins.dst[2:0] == 3'h7) begin
      // counter takes the old address register, which takes the old counter plus one
      {pc, ar} = {ar, 13'(pc + 13'h1)};
    end else begin
      pc = pc + 13'h1;
      ar = pc;
    end
  endtask : exec

  initial begin
    logic [31:0] x, v;
    r = '{default: 8'h00};
    for (int a = 0; a < 256; a++) begin
      tm[0][a] = 8'(rnd());
      tm[1][a] = 8'(rnd());
      i_left.mem[a] = tm[0][a];
      i_right.mem[a] = tm[1][a];
    end
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    check_all();
    // unmapped, read-only and overflow slot writes must all be ignored
    wr(8'h30, 32'h5A);
    wr(`RMM_OFS_PC, 32'h1F);
    wr(8'h60, 32'h1);
    for (int i = 1; i < 15; i++) begin
      if (i != 7 && i != 8) begin
        r[i] = 8'(rnd());
        wr(8'h40 + 8'(4 * i), {24'h0, r[i]});
      end
    end
    rd(8'h30, v);
    chk("unmapped read", v, 32'h0);
    rd(8'h60, v);
    chk("overflow slot", v, 32'h0);
    // accumulator loaded by an instruction so its alu copy agrees
    exec('{3'h0, 5'h01, 3'h0, 5'h00});
    exec('{3'h0, 5'h02, 3'h0, 5'h07});
    exec('{3'h0, 5'h03, 3'h0, 5'h0F});
    check_all();
    repeat (150) begin
      x = rnd();
      if (x[23:22] == 2'h0) begin
        ar = 13'(rnd());
        wr(`RMM_OFS_ADDR, {19'h0, ar});
      end
      exec('{(x[7:4] == 4'h0) ? x[2:0] : {1'b0, x[1:0]}, x[12:8], x[20:18], x[17:13]});
      check_all();
    end
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : test_rmm_datapath

`default_nettype wire
